// >>> rtl/isp_flash_ctrl.sv
/*
 In-system flash programming control: the special function registers,
 the idle-request trigger, core stall, software reset and loader select.
 Assumes the core presents one-cycle SFR read/write strobes on clk_i,
 a one-cycle pulse when it sets the idle request bit, and an external
 reset controller that turns sw_reset_o into a whole-device reset.
*/
`timescale 1ns/1ns
`default_nettype none
module isp_flash_ctrl (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Special function register bus
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic        sfr_wr_i,
	input  wire logic        sfr_rd_i,
	input  wire logic [7:0]  sfr_wdata_i,
	output logic [7:0]       sfr_rdata_o,
	output logic             sfr_hit_o,
	// Core status and control
	input  wire logic        idle_request_bit_i,
	input  wire logic        wake_i,
	input  wire logic        exec_in_loader_i,
	output logic             core_stall_o,
	output logic             core_idle_o,
	output logic             loader_fetch_o,
	output logic             sw_reset_o,
	// Boot strap pin
	input  wire logic        hw_boot_pin_i,
	// Flash arrays
	input  wire logic        flash_ack_i,
	input  wire logic [7:0]  flash_rdata_i,
	output logic             flash_req_o,
	output logic             flash_erase_o,
	output logic             flash_program_o,
	output logic             flash_bank_o,
	output logic             flash_oe_n_o,
	output logic             flash_ce_n_o,
	output logic [15:0]      flash_addr_o,
	output logic [7:0]       flash_wdata_o
);
	isp_op_if op ();

	// Register decode, used for both reads and writes
	function automatic logic [2:0] reg_sel(input logic [7:0] a);
		case (a)
		isp_pkg::OFS_CHIP_CONTROL: reg_sel = 3'h1;
		isp_pkg::OFS_ADDR_LOW:     reg_sel = 3'h2;
		isp_pkg::OFS_ADDR_HIGH:    reg_sel = 3'h3;
		isp_pkg::OFS_DATA_BYTE:    reg_sel = 3'h4;
		isp_pkg::OFS_OP_MODE:      reg_sel = 3'h5;
		default:                   reg_sel = 3'h0;
		endcase
	endfunction

	logic [2:0] sel;
	logic       wr_ctrl;
	logic       wr_alo;
	logic       wr_ahi;
	logic       wr_data;
	logic       wr_mode;

	assign sel     = reg_sel(sfr_addr_i);
	assign wr_ctrl = sfr_wr_i && (sel == 3'h1);
	assign wr_alo  = sfr_wr_i && (sel == 3'h2);
	assign wr_ahi  = sfr_wr_i && (sel == 3'h3);
	assign wr_data = sfr_wr_i && (sel == 3'h4);
	assign wr_mode = sfr_wr_i && (sel == 3'h5);

	// Boot strap: synchronised, then captured once after reset release
	logic hw_boot_sync;
	logic boot_taken_r, boot_taken_nxt;
	logic hw_boot_r, hw_boot_nxt;

	isp_sync2 u_boot_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.d_i     (hw_boot_pin_i),
		.q_o     (hw_boot_sync)
	);

	// Synchroniser needs two edges before its output means anything
	logic [1:0] boot_wait_r, boot_wait_nxt;

	always_comb begin
		boot_wait_nxt  = boot_wait_r;
		boot_taken_nxt = boot_taken_r;
		hw_boot_nxt    = hw_boot_r;
		if (!boot_taken_r) begin
			if (boot_wait_r == 2'h2) begin
				boot_taken_nxt = 1'b1;
				hw_boot_nxt    = hw_boot_sync;
			end else begin
				boot_wait_nxt = boot_wait_r + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			boot_wait_r  <= 2'h0;
			boot_taken_r <= 1'b0;
			hw_boot_r    <= 1'b0;
		end else begin
			boot_wait_r  <= boot_wait_nxt;
			boot_taken_r <= boot_taken_nxt;
			hw_boot_r    <= hw_boot_nxt;
		end
	end

	// Chip control: enable, loader select, software reset
	logic       prog_en_r, prog_en_nxt;
	logic       ldr_sel_r, ldr_sel_nxt;
	logic       software_reset_request_r, software_reset_request_nxt;
	logic [3:0] software_reset_request_cnt_r, software_reset_request_cnt_nxt;

	always_comb begin
		prog_en_nxt   = prog_en_r;
		ldr_sel_nxt   = ldr_sel_r;
		software_reset_request_nxt     = software_reset_request_r;
		software_reset_request_cnt_nxt = software_reset_request_cnt_r;
		if (wr_ctrl) begin
			prog_en_nxt = sfr_wdata_i[isp_pkg::BIT_PROG_ENABLE];
			ldr_sel_nxt = sfr_wdata_i[isp_pkg::BIT_LOADER_SEL];
		end
		// Pulse runs its full width, then the bit clears itself
		if (software_reset_request_r) begin
			if (software_reset_request_cnt_r == isp_pkg::SW_RESET_LAST) begin
				software_reset_request_nxt     = 1'b0;
				software_reset_request_cnt_nxt = 4'h0;
			end else begin
				software_reset_request_cnt_nxt = software_reset_request_cnt_r + 4'h1;
			end
		end else if (wr_ctrl && sfr_wdata_i[isp_pkg::BIT_SW_RESET]) begin
			software_reset_request_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prog_en_r   <= 1'b0;
			ldr_sel_r   <= 1'b0;
			software_reset_request_r     <= 1'b0;
			software_reset_request_cnt_r <= 4'h0;
		end else begin
			prog_en_r   <= prog_en_nxt;
			ldr_sel_r   <= ldr_sel_nxt;
			software_reset_request_r     <= software_reset_request_nxt;
			software_reset_request_cnt_r <= software_reset_request_cnt_nxt;
		end
	end

	// Address, data and operation mode registers
	logic [7:0] addr_lo_r, addr_lo_nxt;
	logic [7:0] addr_hi_r, addr_hi_nxt;
	logic [7:0] data_r, data_nxt;
	logic [7:0] mode_r, mode_nxt;

	always_comb begin
		addr_lo_nxt = wr_alo ? sfr_wdata_i : addr_lo_r;
		addr_hi_nxt = wr_ahi ? sfr_wdata_i : addr_hi_r;
		mode_nxt    = wr_mode ? sfr_wdata_i : mode_r;
		mode_nxt[7] = 1'b0;
		// Returned read byte wins; the core is stalled anyway
		if (op.rd_valid) begin
			data_nxt = op.rdata;
		end else if (wr_data) begin
			data_nxt = sfr_wdata_i;
		end else begin
			data_nxt = data_r;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			addr_lo_r <= isp_pkg::RST_BYTE;
			addr_hi_r <= isp_pkg::RST_BYTE;
			data_r    <= isp_pkg::RST_BYTE;
			mode_r    <= isp_pkg::RST_OP_MODE;
		end else begin
			addr_lo_r <= addr_lo_nxt;
			addr_hi_r <= addr_hi_nxt;
			data_r    <= data_nxt;
			mode_r    <= mode_nxt;
		end
	end

	// Operation fields handed to the sequencer
	assign op.addr    = {addr_hi_r, addr_lo_r};
	assign op.wdata   = data_r;
	assign op.bank    = mode_r[isp_pkg::BIT_BANK_SEL];
	assign op.oe_n    = mode_r[isp_pkg::BIT_OE_N];
	assign op.ce_n    = mode_r[isp_pkg::BIT_CE_N];
	assign op.op_code = mode_r[isp_pkg::OP_CODE_MSB:0];

	// Idle request: flash operation in programming mode, true idle else
	typedef enum logic [1:0] {C_RUN, C_FLASH, C_IDLE} core_state_t;

	core_state_t core_r, core_nxt;
	logic        start_r, start_nxt;
	logic        stall_r, stall_nxt;
	logic        idle_r, idle_nxt;

	always_comb begin
		core_nxt  = core_r;
		start_nxt = 1'b0;
		stall_nxt = stall_r;
		idle_nxt  = idle_r;
		case (core_r)
		C_RUN: if (idle_request_bit_i) begin
			if (prog_en_r) begin
				start_nxt = 1'b1;
				stall_nxt = 1'b1;
				core_nxt  = C_FLASH;
			end else begin
				idle_nxt = 1'b1;
				core_nxt = C_IDLE;
			end
		end
		C_FLASH: if (op.done) begin
			stall_nxt = 1'b0;
			core_nxt  = C_RUN;
		end
		C_IDLE: if (wake_i) begin
			idle_nxt = 1'b0;
			core_nxt = C_RUN;
		end
		default: core_nxt = C_RUN;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			core_r  <= C_RUN;
			start_r <= 1'b0;
			stall_r <= 1'b0;
			idle_r  <= 1'b0;
		end else begin
			core_r  <= core_nxt;
			start_r <= start_nxt;
			stall_r <= stall_nxt;
			idle_r  <= idle_nxt;
		end
	end

	assign op.start = start_r;

	isp_flash_seq u_seq (
		.clk_i           (clk_i),
		.rst_b_i         (rst_b_i),
		.op              (op.seq),
		.flash_ack_i     (flash_ack_i),
		.flash_rdata_i   (flash_rdata_i),
		.flash_req_o     (flash_req_o),
		.flash_erase_o   (flash_erase_o),
		.flash_program_o (flash_program_o),
		.flash_bank_o    (flash_bank_o),
		.flash_oe_n_o    (flash_oe_n_o),
		.flash_ce_n_o    (flash_ce_n_o),
		.flash_addr_o    (flash_addr_o),
		.flash_wdata_o   (flash_wdata_o)
	);

	// Read path, registered one cycle after the strobe
	logic [7:0] rdata_r, rdata_nxt;
	logic       hit_r, hit_nxt;
	logic [7:0] ctrl_view;

	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[isp_pkg::BIT_SW_RESET]    = hw_boot_r;
		ctrl_view[isp_pkg::BIT_EXEC_BANK]   = exec_in_loader_i;
		ctrl_view[isp_pkg::BIT_LOADER_SEL]  = ldr_sel_r;
		ctrl_view[isp_pkg::BIT_PROG_ENABLE] = prog_en_r;
	end

	always_comb begin
		rdata_nxt = rdata_r;
		hit_nxt   = 1'b0;
		if (sfr_rd_i) begin
			hit_nxt = (sel != 3'h0);
			case (sel)
			3'h1:    rdata_nxt = ctrl_view;
			3'h2:    rdata_nxt = addr_lo_r;
			3'h3:    rdata_nxt = addr_hi_r;
			3'h4:    rdata_nxt = data_r;
			3'h5:    rdata_nxt = mode_r;
			default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// Outputs held in flops
	logic ldr_fetch_r;
	logic software_reset_request_out_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_r     <= 8'h00;
			hit_r       <= 1'b0;
			ldr_fetch_r <= 1'b0;
			software_reset_request_out_r <= 1'b0;
		end else begin
			rdata_r     <= rdata_nxt;
			hit_r       <= hit_nxt;
			ldr_fetch_r <= ldr_sel_nxt;
			software_reset_request_out_r <= software_reset_request_nxt;
		end
	end

	assign sfr_rdata_o    = rdata_r;
	assign sfr_hit_o      = hit_r;
	assign core_stall_o   = stall_r;
	assign core_idle_o    = idle_r;
	assign loader_fetch_o = ldr_fetch_r;
	assign sw_reset_o     = software_reset_request_out_r;
endmodule // isp_flash_ctrl
`default_nettype wire

// >>> rtl/isp_pkg.sv
/*
 Constants for the in-system flash programming block: register offsets,
 field positions, operation codes and timing counts.
 Assumes a 100 MHz core clock and an 8-bit special function register bus.
*/
// Function
// - Software reset bit resets whole device, self-clears
// - Reading reset bit shows hardware boot reboot
// - Read-only flag shows executing bank
// - Loader select bit steers fetches to loader
// - Enable bit enters mode running selected operation
// - Idle request starts operation while enabled
// - Clearing enable restores normal idle behaviour
// - Two address bytes form 16-bit flash address
// - Data register supplies program byte, returns reads
// - Bank bit picks application or loader flash
// - Mode register holds active-low flash enables
// - Code 0010 erases whole selected bank
// - Code 0001 programs addressed byte
// - Code 0000 reads addressed byte
package isp_pkg;
	// Register offsets on the special function register bus
	localparam logic [7:0] OFS_CHIP_CONTROL = 8'h9f;
	localparam logic [7:0] OFS_ADDR_LOW     = 8'hac;
	localparam logic [7:0] OFS_ADDR_HIGH    = 8'had;
	localparam logic [7:0] OFS_DATA_BYTE    = 8'hae;
	localparam logic [7:0] OFS_OP_MODE      = 8'haf;

	// Chip control fields
	localparam int BIT_SW_RESET    = 7;
	localparam int BIT_EXEC_BANK   = 2;
	localparam int BIT_LOADER_SEL  = 1;
	localparam int BIT_PROG_ENABLE = 0;

	// Operation mode fields
	localparam int BIT_BANK_SEL    = 6;
	localparam int BIT_OE_N        = 5;
	localparam int BIT_CE_N        = 4;
	localparam int OP_CODE_MSB     = 3;

	// Reset values
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [7:0] RST_OP_MODE = 8'h30;

	// Operation codes
	localparam logic [3:0] OP_READ    = 4'h0;
	localparam logic [3:0] OP_PROGRAM = 4'h1;
	localparam logic [3:0] OP_ERASE   = 4'h2;

	// Software reset pulse width
	localparam int CLK_PERIOD_NS     = 10;
	localparam int SW_RESET_NS       = 40;
	localparam int SW_RESET_CYCLES   =
		(SW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SW_RESET_LAST = 4'(SW_RESET_CYCLES - 1);
endpackage

// >>> rtl/isp_op_if.sv
/*
 Carrier between the register side and the flash sequencer.
 Assumes both ends share clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
interface isp_op_if;
	logic        start;
	logic [3:0]  op_code;
	logic        bank;
	logic        oe_n;
	logic        ce_n;
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic        done;
	logic        rd_valid;
	logic [7:0]  rdata;

	modport ctrl (
		output start, op_code, bank, oe_n, ce_n, addr, wdata,
		input  done, rd_valid, rdata
	);
	modport seq (
		input  start, op_code, bank, oe_n, ce_n, addr, wdata,
		output done, rd_valid, rdata
	);
endinterface
`default_nettype wire

// >>> rtl/isp_flash_seq.sv
/*
 Flash sequencer: runs one erase, program or read on the flash arrays.
 Assumes the flash arrays sit on clk_i and answer each request with a
 one-cycle flash_ack_i, read data valid in that cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module isp_flash_seq (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Operation carrier
	isp_op_if.seq            op,
	// Flash array
	input  wire logic        flash_ack_i,
	input  wire logic [7:0]  flash_rdata_i,
	output logic             flash_req_o,
	output logic             flash_erase_o,
	output logic             flash_program_o,
	output logic             flash_bank_o,
	output logic             flash_oe_n_o,
	output logic             flash_ce_n_o,
	output logic [15:0]      flash_addr_o,
	output logic [7:0]       flash_wdata_o
);
	typedef enum logic [1:0] {S_IDLE, S_BUSY, S_DONE} seq_state_t;

	seq_state_t  state_r, state_nxt;
	logic        req_r, req_nxt;
	logic        erase_r, erase_nxt;
	logic        prog_r, prog_nxt;
	logic        bank_r, bank_nxt;
	logic        oe_n_r, oe_n_nxt;
	logic        ce_n_r, ce_n_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic [7:0]  wdata_r, wdata_nxt;
	logic [7:0]  rdata_r, rdata_nxt;
	logic        done_r, done_nxt;
	logic        rdv_r, rdv_nxt;
	logic        legal;

	// Enables must match the operation; anything else ends without access
	always_comb begin
		case (op.op_code)
		isp_pkg::OP_ERASE:   legal = op.oe_n && !op.ce_n;
		isp_pkg::OP_PROGRAM: legal = op.oe_n && !op.ce_n;
		isp_pkg::OP_READ:    legal = !op.oe_n && !op.ce_n;
		default:             legal = 1'b0;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		req_nxt   = req_r;
		erase_nxt = erase_r;
		prog_nxt  = prog_r;
		bank_nxt  = bank_r;
		oe_n_nxt  = oe_n_r;
		ce_n_nxt  = ce_n_r;
		addr_nxt  = addr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		done_nxt  = 1'b0;
		rdv_nxt   = 1'b0;
		case (state_r)
		S_IDLE: if (op.start) begin
			bank_nxt  = op.bank;
			addr_nxt  = op.addr;
			wdata_nxt = op.wdata;
			if (legal) begin
				req_nxt   = 1'b1;
				oe_n_nxt  = op.oe_n;
				ce_n_nxt  = op.ce_n;
				erase_nxt = (op.op_code == isp_pkg::OP_ERASE);
				prog_nxt  = (op.op_code == isp_pkg::OP_PROGRAM);
				state_nxt = S_BUSY;
			end else begin
				state_nxt = S_DONE;
			end
		end
		S_BUSY: if (flash_ack_i) begin
			req_nxt   = 1'b0;
			oe_n_nxt  = 1'b1;
			ce_n_nxt  = 1'b1;
			rdv_nxt   = !erase_r && !prog_r;
			rdata_nxt = flash_rdata_i;
			erase_nxt = 1'b0;
			prog_nxt  = 1'b0;
			state_nxt = S_DONE;
		end
		S_DONE: begin
			done_nxt  = 1'b1;
			state_nxt = S_IDLE;
		end
		default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= S_IDLE;
			req_r   <= 1'b0;
			erase_r <= 1'b0;
			prog_r  <= 1'b0;
			bank_r  <= 1'b0;
			oe_n_r  <= 1'b1;
			ce_n_r  <= 1'b1;
			addr_r  <= 16'h0000;
			wdata_r <= 8'h00;
			rdata_r <= 8'h00;
			done_r  <= 1'b0;
			rdv_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			req_r   <= req_nxt;
			erase_r <= erase_nxt;
			prog_r  <= prog_nxt;
			bank_r  <= bank_nxt;
			oe_n_r  <= oe_n_nxt;
			ce_n_r  <= ce_n_nxt;
			addr_r  <= addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			done_r  <= done_nxt;
			rdv_r   <= rdv_nxt;
		end
	end

	assign op.done         = done_r;
	assign op.rd_valid     = rdv_r;
	assign op.rdata        = rdata_r;
	assign flash_req_o     = req_r;
	assign flash_erase_o   = erase_r;
	assign flash_program_o = prog_r;
	assign flash_bank_o    = bank_r;
	assign flash_oe_n_o    = oe_n_r;
	assign flash_ce_n_o    = ce_n_r;
	assign flash_addr_o    = addr_r;
	assign flash_wdata_o   = wdata_r;
endmodule // isp_flash_seq
`default_nettype wire

// >>> rtl/isp_sync2.sv
/*
 Two-flop synchroniser for a level from a pin.
 Assumes the level is slow compared with clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module isp_sync2 (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// Level
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_r;
	logic sync_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;
endmodule // isp_sync2
`default_nettype wire

// >>> test/isp_flash_model.sv
/*
 Behavioural model of the two flash arrays behind the sequencer.
 Assumes the req/ack handshake on clk_i; contents survive a reset.
*/
`timescale 1ns/1ns
`default_nettype none
module isp_flash_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Request from the sequencer
	input  wire logic        req_i,
	input  wire logic        erase_i,
	input  wire logic        program_i,
	input  wire logic        bank_i,
	input  wire logic        oe_n_i,
	input  wire logic        ce_n_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	// Answer latency set by the bench
	input  wire logic [3:0]  delay_i,
	// Answer
	output logic             ack_o,
	output logic [7:0]       rdata_o
);
	localparam logic [7:0] ERASED = 8'hff;
	logic [7:0] mem [0:1][int];
	logic [3:0] cnt_r;
	logic       done_r;
	int         key;

	// Loader bank holds 4KB, so only 12 address bits reach it
	always_comb key = bank_i ? int'(addr_i[11:0]) : int'(addr_i);

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_o <= 1'b0;
			rdata_o <= 8'h5a;
			cnt_r <= 4'h0;
			done_r <= 1'b0;
		end else if (req_i && !done_r && cnt_r == delay_i) begin
			ack_o <= 1'b1;
			done_r <= 1'b1;
			if (ce_n_i)
				rdata_o <= ~rdata_o;
			else if (erase_i)
				mem[bank_i].delete();
			else if (program_i)
				mem[bank_i][key] = wdata_i;
			else if (oe_n_i)
				rdata_o <= ~rdata_o;
			else if (mem[bank_i].exists(key))
				rdata_o <= mem[bank_i][key];
			else
				rdata_o <= ERASED;
		end else begin
			// Data line does not hold its value outside the ack cycle
			ack_o <= 1'b0;
			rdata_o <= ~rdata_o;
			cnt_r <= (req_i && !done_r) ? cnt_r + 4'h1 : 4'h0;
			if (!req_i)
				done_r <= 1'b0;
		end
	end
endmodule // isp_flash_model
`default_nettype wire

// >>> test/isp_flash_ctrl_checker.sv
/*
 Port assertions for the flash programming control.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module isp_flash_ctrl_checker (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	// Register bus
	input wire logic [7:0]  sfr_addr_i,
	input wire logic        sfr_wr_i,
	input wire logic        sfr_rd_i,
	input wire logic [7:0]  sfr_wdata_i,
	input wire logic [7:0]  sfr_rdata_o,
	// Core
	input wire logic        idle_request_bit_i,
	input wire logic        exec_in_loader_i,
	input wire logic        core_stall_o,
	input wire logic        core_idle_o,
	input wire logic        loader_fetch_o,
	input wire logic        sw_reset_o,
	// Flash
	input wire logic        flash_ack_i,
	input wire logic        flash_req_o,
	input wire logic        flash_erase_o,
	input wire logic        flash_program_o,
	input wire logic        flash_bank_o,
	input wire logic        flash_oe_n_o,
	input wire logic        flash_ce_n_o,
	input wire logic [15:0] flash_addr_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	wire logic ctl_wr;
	wire logic ctl_rd;
	logic      en_r;
	logic      en_nxt;
	assign ctl_wr = sfr_wr_i && sfr_addr_i == isp_pkg::OFS_CHIP_CONTROL;
	assign ctl_rd = sfr_rd_i && sfr_addr_i == isp_pkg::OFS_CHIP_CONTROL;
	// Shadow of the enable bit, needed to tell stall from true idle
	always_comb en_nxt = ctl_wr ? sfr_wdata_i[0] : en_r;
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i) en_r <= 1'b0;
		else en_r <= en_nxt;

	sequence s_pulse; sw_reset_o [*4] ##1 !sw_reset_o; endsequence
	// Done reaches the core one cycle after the sequencer leaves busy
	sequence s_finish;
		!flash_req_o ##1 core_stall_o ##1 !core_stall_o; endsequence

	property p_sw_reset;
		ctl_wr && sfr_wdata_i[7] && !sw_reset_o |=> s_pulse; endproperty
	property p_loader;
		ctl_wr |=> loader_fetch_o == $past(sfr_wdata_i[1]); endproperty
	property p_exec;
		ctl_rd |=> sfr_rdata_o[2] == $past(exec_in_loader_i); endproperty
	property p_trigger;
		idle_request_bit_i && !core_stall_o && !core_idle_o |=>
		($past(en_r) ? core_stall_o && !core_idle_o :
		core_idle_o && !core_stall_o);
	endproperty
	property p_req_stall; flash_req_o |-> core_stall_o; endproperty
	property p_done; flash_req_o && flash_ack_i |=> s_finish; endproperty
	property p_hold;
		flash_req_o && !flash_ack_i |=> flash_req_o &&
		$stable(flash_addr_o) && $stable(flash_bank_o); endproperty
	property p_read_en; flash_req_o && !flash_erase_o && !flash_program_o
		|-> !flash_oe_n_o && !flash_ce_n_o; endproperty
	property p_write_en; flash_req_o && (flash_erase_o || flash_program_o)
		|-> flash_oe_n_o && !flash_ce_n_o; endproperty
	property p_idle_en;
		!flash_req_o |-> flash_oe_n_o && flash_ce_n_o; endproperty

	a_sw_reset: assert property (p_sw_reset)
		else $error("software reset pulse wrong");
	a_loader: assert property (p_loader)
		else $error("loader fetch select wrong");
	a_exec: assert property (p_exec)
		else $error("executing bank flag wrong");
	a_trigger: assert property (p_trigger)
		else $error("idle request handled wrongly");
	a_req_stall: assert property (p_req_stall)
		else $error("flash request without core stall");
	a_done: assert property (p_done)
		else $error("operation end sequence wrong");
	a_hold: assert property (p_hold)
		else $error("request changed before ack");
	a_read_en: assert property (p_read_en)
		else $error("read enables wrong");
	a_write_en: assert property (p_write_en)
		else $error("erase or program enables wrong");
	a_idle_en: assert property (p_idle_en)
		else $error("flash enables active while idle");
endmodule // isp_flash_ctrl_checker
bind isp_flash_ctrl isp_flash_ctrl_checker isp_flash_ctrl_checker_i (
	.clk_i, .rst_b_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
	.sfr_rdata_o, .idle_request_bit_i, .exec_in_loader_i, .core_stall_o,
	.core_idle_o, .loader_fetch_o, .sw_reset_o, .flash_ack_i, .flash_req_o,
	.flash_erase_o, .flash_program_o, .flash_bank_o, .flash_oe_n_o,
	.flash_ce_n_o, .flash_addr_o
);
`default_nettype wire

// >>> test/tb_in_system_flash_programming.sv
/*
 Self-checking bench for the flash programming control.
 Assumes the flash model in isp_flash_model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_in_system_flash_programming;
	logic        clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic [7:0]  sfr_addr_i = 8'h00;
	logic [7:0]  sfr_wdata_i = 8'h00;
	logic        sfr_wr_i = 1'b0;
	logic        sfr_rd_i = 1'b0;
	logic        idle_request_bit_i = 1'b0;
	logic        wake_i = 1'b0;
	logic        exec_in_loader_i = 1'b0;
	logic        hw_boot_pin_i = 1'b0;
	logic [3:0]  delay = 4'h0;
	logic [7:0]  sfr_rdata_o, flash_rdata_i, flash_wdata_o;
	logic        sfr_hit_o, core_stall_o, core_idle_o, loader_fetch_o;
	logic        sw_reset_o, flash_ack_i, flash_req_o, flash_erase_o;
	logic        flash_program_o, flash_bank_o, flash_oe_n_o, flash_ce_n_o;
	logic [15:0] flash_addr_o;
	logic        saw_req;
	logic [7:0]  mir [0:1][int];
	int          bad_count = 0;
	int          compares = 0;

	isp_flash_ctrl isp_flash_ctrl_i (.clk_i, .rst_b_i, .sfr_addr_i,
		.sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o,
		.idle_request_bit_i, .wake_i, .exec_in_loader_i, .core_stall_o,
		.core_idle_o, .loader_fetch_o, .sw_reset_o, .hw_boot_pin_i,
		.flash_ack_i, .flash_rdata_i, .flash_req_o, .flash_erase_o,
		.flash_program_o, .flash_bank_o, .flash_oe_n_o, .flash_ce_n_o,
		.flash_addr_o, .flash_wdata_o);
	isp_flash_model isp_flash_model_i (.clk_i, .rst_b_i,
		.req_i(flash_req_o), .erase_i(flash_erase_o),
		.program_i(flash_program_o), .bank_i(flash_bank_o),
		.oe_n_i(flash_oe_n_o), .ce_n_i(flash_ce_n_o), .addr_i(flash_addr_o),
		.wdata_i(flash_wdata_o), .delay_i(delay), .ack_o(flash_ack_i),
		.rdata_o(flash_rdata_i));

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) if (flash_req_o === 1'b1) saw_req <= 1'b1;

	task results();
		if (bad_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = 1'b1;
		@(negedge clk_i);
		sfr_wr_i = 1'b0;
	endtask
	function logic mapped(logic [7:0] a);
		return a inside {isp_pkg::OFS_CHIP_CONTROL, isp_pkg::OFS_ADDR_LOW,
			isp_pkg::OFS_ADDR_HIGH, isp_pkg::OFS_DATA_BYTE,
			isp_pkg::OFS_OP_MODE};
	endfunction
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_rd_i = 1'b1;
		@(negedge clk_i);
		sfr_rd_i = 1'b0;
		d = sfr_rdata_o;
		check({7'h00, sfr_hit_o}, {7'h00, mapped(a)});
	endtask
	task trig();
		@(negedge clk_i);
		saw_req = 1'b0;
		idle_request_bit_i = 1'b1;
		@(negedge clk_i);
		idle_request_bit_i = 1'b0;
	endtask
	task op(input logic [7:0] mode);
		wr(isp_pkg::OFS_OP_MODE, mode);
		trig();
		for (int i = 0; i < 60 && core_stall_o !== 1'b0; i++)
			@(negedge clk_i);
		check({7'h00, core_stall_o}, 8'h00);
	endtask
	function logic [7:0] md(logic b, logic oe_n, logic [3:0] c);
		return {1'b0, b, oe_n, 1'b0, c};
	endfunction
	function logic [7:0] expb(logic b, logic [15:0] a);
		// Never-programmed or erased bytes read as all ones
		return mir[b].exists(int'(a)) ? mir[b][int'(a)] : 8'hff;
	endfunction
	task rdf(input logic b, input logic [15:0] a);
		logic [7:0] d;
		wr(isp_pkg::OFS_ADDR_LOW, a[7:0]);
		wr(isp_pkg::OFS_ADDR_HIGH, a[15:8]);
		op(md(b, 1'b0, isp_pkg::OP_READ));
		rd(isp_pkg::OFS_DATA_BYTE, d);
		check(d, expb(b, a));
	endtask
	task do_reset(input logic boot);
		rst_b_i = 1'b0;
		hw_boot_pin_i = boot;
		repeat (8) @(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (4) @(negedge clk_i);
	endtask

	initial begin
		logic [7:0]  d;
		logic [15:0] a;
		logic        b;
		void'($urandom(98567));
		do_reset(1'b0);
		rd(isp_pkg::OFS_OP_MODE, d);
		check(d, isp_pkg::RST_OP_MODE);
		exec_in_loader_i = 1'b1;
		wr(isp_pkg::OFS_CHIP_CONTROL, 8'h07);
		@(negedge clk_i);
		check({7'h00, loader_fetch_o}, 8'h01);
		rd(isp_pkg::OFS_CHIP_CONTROL, d);
		check({4'h0, d[7], d[2:0]}, 8'h07);
		exec_in_loader_i = 1'b0;
		wr(isp_pkg::OFS_CHIP_CONTROL, 8'h05);
		rd(isp_pkg::OFS_CHIP_CONTROL, d);
		check({4'h0, d[7], d[2:0]}, 8'h01);
		for (int n = 0; n < 40; n++) begin
			b = (n < 2) ? n[0] : 1'($urandom);
			a = b ? 16'($urandom_range(4095, 0)) : 16'($urandom);
			if (n < 2)
				a = b ? 16'h0fff : 16'hffff;
			d = 8'($urandom);
			delay = 4'($urandom_range(6, 0));
			wr(isp_pkg::OFS_ADDR_LOW, a[7:0]);
			wr(isp_pkg::OFS_ADDR_HIGH, a[15:8]);
			wr(isp_pkg::OFS_DATA_BYTE, d);
			op(md(b, 1'b1, isp_pkg::OP_PROGRAM));
			mir[b][int'(a)] = d;
			rdf(b, a);
		end
		op(md(1'b0, 1'b1, isp_pkg::OP_ERASE));
		mir[0].delete();
		rdf(1'b0, 16'hffff);
		rdf(1'b1, 16'h0fff);
		op(md(1'b1, 1'b1, isp_pkg::OP_ERASE));
		mir[1].delete();
		rdf(1'b1, 16'h0fff);
		rd(8'h00, d);
		check(d, 8'h00);
		op(md(1'b0, 1'b1, isp_pkg::OP_READ));
		check({7'h00, saw_req}, 8'h00);
		op(md(1'b0, 1'b0, isp_pkg::OP_PROGRAM));
		check({7'h00, saw_req}, 8'h00);
		op(md(1'b0, 1'b1, 4'h3));
		check({7'h00, saw_req}, 8'h00);
		wr(isp_pkg::OFS_CHIP_CONTROL, 8'h00);
		trig();
		check({6'h00, core_idle_o, saw_req}, 8'h02);
		wake_i = 1'b1;
		@(negedge clk_i);
		wake_i = 1'b0;
		repeat (2) @(negedge clk_i);
		check({7'h00, core_idle_o}, 8'h00);
		wr(isp_pkg::OFS_CHIP_CONTROL, 8'h80);
		check({7'h00, sw_reset_o}, 8'h01);
		repeat (3) @(negedge clk_i);
		check({7'h00, sw_reset_o}, 8'h01);
		@(negedge clk_i);
		check({7'h00, sw_reset_o}, 8'h00);
		rd(isp_pkg::OFS_CHIP_CONTROL, d);
		check({7'h00, d[7]}, 8'h00);
		do_reset(1'b1);
		rd(isp_pkg::OFS_CHIP_CONTROL, d);
		check({7'h00, d[7]}, 8'h01);
		results();
	end

	// Run needs under two thousand cycles; this allows ample margin
	initial begin
		#400000;
		bad_count++;
		results();
	end
endmodule // tb_in_system_flash_programming
`default_nettype wire
